//--- hdl/fmc_pkg.sv
package fmc_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_MHZ = 250;
	localparam int TACH_TICK_US = 10;
	localparam int TACH_TICK_CYCLES = TACH_TICK_US * CLK_MHZ;
	localparam int FAST_TACH_DIV = 4;
	localparam int FAST_TICK_CYCLES = TACH_TICK_CYCLES / FAST_TACH_DIV;
	localparam int CONV_TIME_MS = 120;
	localparam int BUS_TIMEOUT_MS = 25;
	localparam int TEMP_CHANNELS_DEF = 10;

	// ==========================================================
	// register offsets
	localparam logic [7:0] REG_PART = 8'h3D;
	localparam logic [7:0] REG_MAKER = 8'h3E;
	localparam logic [7:0] REG_REV = 8'h3F;
	localparam logic [7:0] REG_CTRL_A = 8'h40;
	localparam logic [7:0] REG_FAN_STATUS = 8'h42;
	localparam logic [7:0] REG_CTRL_B = 8'h74;
	localparam logic [7:0] REG_FN_SEL = 8'h7F;
	localparam logic [7:0] REG_DIR_LVL = 8'h80;
	localparam logic [7:0] REG_PIN_STATE = 8'h81;
	localparam logic [7:0] REG_TEMP_BASE = 8'h20;
	localparam logic [7:0] REG_TACH_BASE = 8'h2C;
	localparam logic [7:0] REG_MIN_BASE = 8'h58;
	localparam logic [7:0] REG_MAX_BASE = 8'h60;

	// ==========================================================
	// field positions
	localparam int CA_RUN = 0;
	localparam int CA_TMO_DIS = 1;
	localparam int CA_FAST_TACH = 2;
	localparam int CA_LOCK = 3;
	localparam int CA_HF_FAN4 = 4;
	localparam int CA_PIN13_START = 5;
	localparam int CA_STOP_N = 7;
	localparam int CB_SHUTDOWN = 0;
	localparam int CB_FREQ_LSB = 1;
	localparam int CB_TACH_DIS_LSB = 4;
	localparam int STATE_LSB = 4;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CTRL_A = 8'h00;
	localparam logic [7:0] RST_CTRL_B = 8'h00;
	localparam logic [7:0] RST_FN_SEL = 8'h00;
	localparam logic [7:0] RST_DIR_LVL = 8'h00;
	localparam logic [7:0] RST_MIN_LIM = 8'hFF;
	localparam logic [7:0] RST_MAX_LIM = 8'h00;
	localparam logic [7:0] CNT_SAT = 8'hFF;

	// ==========================================================
	// slave address strap
	localparam logic [1:0] STRAP_LOW = 2'b00;
	localparam logic [1:0] STRAP_HIGH = 2'b01;
	localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h2F;
	localparam logic [6:0] SLAVE_ADDR_LOW = 7'h2C;
	localparam logic [6:0] SLAVE_ADDR_FLOAT = 7'h2E;

	typedef enum logic [4:0] {
		BUS_IDLE = 5'b0_0001,
		BUS_RECV = 5'b0_0010,
		BUS_ACK = 5'b0_0100,
		BUS_SEND = 5'b0_1000,
		BUS_MACK = 5'b1_0000
	} fmc_bus_state_type;

	// open-drain pin: out is the level driven while oe is high
	typedef struct packed {
		logic out;
		logic oe;
	} fmc_od_type;

endpackage

//--- hdl/fmc_monitor.sv
`timescale 1ns/1ps

module fmc_monitor
	import fmc_pkg::*;
#(
	parameter int MS_CYCLES = CLK_MHZ * 1000,
	parameter int TEMP_CHANNELS = TEMP_CHANNELS_DEF,
	parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary value
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] REV_CODE = 8'h01 // arbitrary value
)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output fmc_od_type sdaPin,
	input wire logic [3:0] tachIn,
	input wire logic tempChainIn,
	output fmc_od_type tempStartPin,
	input wire logic [1:0] addrStrap,
	input wire logic [3:0] fanDriveIn,
	input wire logic [3:0] auxPinIn,
	output fmc_od_type [3:0] auxPin,
	output fmc_od_type alertPin,
	output logic [3:0] fanFreqHigh,
	output logic shutdownMode
);

	// ==========================================================
	// input synchronisers
	logic [12:0] s1_r, s2_r, s3_r, filt_r, prev_r;
	wire [12:0] rawIn = {addrStrap, auxPinIn, tempChainIn, tachIn, sdaIn, sclIn};
	wire [12:0] agree = ~(s2_r ^ s3_r);

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
			filt_r <= '1;
			prev_r <= '1;
		end else begin
			s1_r <= rawIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= (agree & s3_r) | (~agree & filt_r);
			prev_r <= filt_r;
		end
	end

	wire scl = filt_r[0];
	wire sda = filt_r[1];
	wire [3:0] tach = filt_r[5:2];
	wire [3:0] tachFall = prev_r[5:2] & ~tach;
	wire tempRise = filt_r[6] & ~prev_r[6];
	wire tempFall = prev_r[6] & ~filt_r[6];
	wire [3:0] auxLvl = filt_r[10:7];
	wire [1:0] strap = filt_r[12:11];
	wire sclRise = scl & ~prev_r[0];
	wire sclFall = prev_r[0] & ~scl;
	wire startCond = scl & prev_r[0] & prev_r[1] & ~sda;
	wire stopCond = scl & prev_r[0] & ~prev_r[1] & sda;

	function automatic logic [6:0] strapAddr(input logic [1:0] s);
		if (s == STRAP_HIGH)
			return SLAVE_ADDR_HIGH;
		else if (s == STRAP_LOW)
			return SLAVE_ADDR_LOW;
		else
			return SLAVE_ADDR_FLOAT;
	endfunction

	function automatic logic inBank(input logic [7:0] a, input logic [7:0] base);
		return a[7:2] == base[7:2];
	endfunction

	// ==========================================================
	// registers and timebases
	logic [7:0] ctrlA_r, ctrlB_r, fnSel_r, dirLvl_r, fanStat_r, ptr_r;
	logic [3:0] outState_r;
	logic monOn_r;
	logic [7:0] tachVal_r [4];
	logic [7:0] minLim_r [4];
	logic [7:0] maxLim_r [4];
	logic [7:0] temp_r [TEMP_CHANNELS];
	logic [31:0] msCnt_r;
	logic [11:0] baseDiv_r, fastDiv_r;
	logic [15:0] passCnt_r;
	logic [7:0] sclLowMs_r;

	wire run = monOn_r & ~ctrlB_r[CB_SHUTDOWN];
	wire locked = ctrlA_r[CA_LOCK];
	wire msTick = msCnt_r == 32'(MS_CYCLES - 1);
	wire baseTick = baseDiv_r == 12'(TACH_TICK_CYCLES - 1);
	wire fastTick = fastDiv_r == 12'(FAST_TICK_CYCLES - 1);
	wire tachTick = ctrlA_r[CA_FAST_TACH] ? fastTick : baseTick;
	wire [15:0] passLast = 16'(CONV_TIME_MS * TEMP_CHANNELS - 1);
	wire passStart = run & msTick & (passCnt_r == 16'h0000);

	always_ff @(posedge mclk) begin
		if (rst) begin
			msCnt_r <= '0;
			baseDiv_r <= '0;
			fastDiv_r <= '0;
		end else begin
			msCnt_r <= msTick ? '0 : msCnt_r + 32'h0000_0001;
			baseDiv_r <= baseTick ? '0 : baseDiv_r + 12'h001;
			fastDiv_r <= (fastTick || baseTick) ? '0 : fastDiv_r + 12'h001;
		end
	end

	// ==========================================================
	// serial bus slave
	fmc_bus_state_type busSt_r;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r;
	logic rw_r, isAddr_r, dataPhase_r, sdaOe_r, addrLocked_r;
	logic [6:0] slaveAddr_r;
	logic [7:0] rdData;

	wire byteDone = (busSt_r == BUS_RECV) && sclFall && (bitCnt_r == 4'h8);
	// data bytes after the pointer byte of a write go to the pointed register
	wire wrStb = byteDone && !isAddr_r && dataPhase_r;
	wire rdLoad = (busSt_r == BUS_ACK) && sclFall && rw_r;
	wire busTimeout = !ctrlA_r[CA_TMO_DIS] && (sclLowMs_r == 8'(BUS_TIMEOUT_MS));

	always_ff @(posedge mclk) begin
		if (rst || scl || busSt_r == BUS_IDLE)
			sclLowMs_r <= '0;
		else if (msTick && !busTimeout)
			sclLowMs_r <= sclLowMs_r + 8'h01;
	end

	// slave only: the device never drives the clock line
	always_ff @(posedge mclk) begin
		if (rst) begin
			busSt_r <= BUS_IDLE;
			bitCnt_r <= '0;
			shift_r <= '0;
			rw_r <= 1'b0;
			isAddr_r <= 1'b0;
			dataPhase_r <= 1'b0;
			sdaOe_r <= 1'b0;
			ptr_r <= '0;
			addrLocked_r <= 1'b0;
			slaveAddr_r <= SLAVE_ADDR_FLOAT;
		end else if (startCond) begin
			busSt_r <= BUS_RECV;
			bitCnt_r <= '0;
			isAddr_r <= 1'b1;
			sdaOe_r <= 1'b0;
			// strap caught once, at the first start
			if (!addrLocked_r) begin
				slaveAddr_r <= strapAddr(strap);
				addrLocked_r <= 1'b1;
			end
		end else if (stopCond || busTimeout) begin
			busSt_r <= BUS_IDLE;
			sdaOe_r <= 1'b0;
		end else begin
			case (busSt_r)
				BUS_RECV: begin
					if (sclRise) begin
						shift_r <= {shift_r[6:0], sda};
						bitCnt_r <= bitCnt_r + 4'h1;
					end else if (byteDone) begin
						if (isAddr_r && shift_r[7:1] != slaveAddr_r) begin
							busSt_r <= BUS_IDLE;
						end else begin
							if (isAddr_r) begin
								rw_r <= shift_r[0];
								dataPhase_r <= 1'b0;
							end else begin
								if (!dataPhase_r)
									ptr_r <= shift_r;
								dataPhase_r <= 1'b1;
							end
							sdaOe_r <= 1'b1;
							busSt_r <= BUS_ACK;
						end
					end
				end
				BUS_ACK: begin
					if (sclFall) begin
						isAddr_r <= 1'b0;
						if (rw_r) begin
							shift_r <= rdData;
							sdaOe_r <= ~rdData[7];
							bitCnt_r <= 4'h1;
							busSt_r <= BUS_SEND;
						end else begin
							sdaOe_r <= 1'b0;
							bitCnt_r <= '0;
							busSt_r <= BUS_RECV;
						end
					end
				end
				BUS_SEND: begin
					if (sclFall) begin
						if (bitCnt_r == 4'h8) begin
							sdaOe_r <= 1'b0;
							busSt_r <= BUS_MACK;
						end else begin
							sdaOe_r <= ~shift_r[6];
							shift_r <= {shift_r[6:0], 1'b0};
							bitCnt_r <= bitCnt_r + 4'h1;
						end
					end
				end
				BUS_MACK: begin
					// master ack repeats the same register, nack ends the read
					if (sclRise)
						busSt_r <= sda ? BUS_IDLE : BUS_ACK;
				end
				default: begin
					sdaOe_r <= 1'b0;
					if (busSt_r != BUS_IDLE)
						busSt_r <= BUS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// general pins
	logic [3:0] pinEn, pinDir, pinPol, pinState;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// pin 1 maps to bit 3
			pinEn[i] = fnSel_r[3 - i];
			// direction bits 7, 5, 3, 1
			pinDir[i] = dirLvl_r[7 - 2 * i];
			// polarity bits 6, 4, 2, 0
			pinPol[i] = dirLvl_r[6 - 2 * i];
			// input state set at asserted level
			pinState[i] = pinDir[i] ? outState_r[i] : (auxLvl[i] == pinPol[i]);
		end
	end

	// ==========================================================
	// register read
	wire [7:0] tempIdx = ptr_r - REG_TEMP_BASE;
	wire tempHit = (ptr_r >= REG_TEMP_BASE) && (tempIdx < 8'(TEMP_CHANNELS));

	always_comb begin
		rdData = 8'h00;
		case (ptr_r)
			REG_PART: rdData = PART_CODE;
			REG_MAKER: rdData = MAKER_CODE;
			REG_REV: rdData = REV_CODE;
			REG_CTRL_A: rdData = {ctrlA_r[7:1], monOn_r};
			REG_FAN_STATUS: rdData = fanStat_r;
			REG_CTRL_B: rdData = ctrlB_r;
			REG_FN_SEL: rdData = fnSel_r;
			REG_DIR_LVL: rdData = dirLvl_r;
			REG_PIN_STATE: rdData = {pinState, 4'h0};
			default: begin
				if (inBank(ptr_r, REG_TACH_BASE))
					rdData = tachVal_r[ptr_r[1:0]];
				else if (inBank(ptr_r, REG_MIN_BASE))
					rdData = minLim_r[ptr_r[1:0]];
				else if (inBank(ptr_r, REG_MAX_BASE))
					rdData = maxLim_r[ptr_r[1:0]];
				else if (tempHit)
					rdData = temp_r[tempIdx[3:0]];
			end
		endcase
	end

	// ==========================================================
	// register write
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlA_r <= RST_CTRL_A;
			ctrlB_r <= RST_CTRL_B;
			fnSel_r <= RST_FN_SEL;
			dirLvl_r <= RST_DIR_LVL;
			outState_r <= '0;
			monOn_r <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				minLim_r[i] <= RST_MIN_LIM;
				maxLim_r[i] <= RST_MAX_LIM;
			end
		end else if (wrStb) begin
			case (ptr_r)
				REG_CTRL_A: begin
					// lock bit stays set until reset
					ctrlA_r <= shift_r | {4'h0, locked, 3'h0};
					if (shift_r[CA_RUN])
						monOn_r <= 1'b1;
					else if (!shift_r[CA_STOP_N])
						monOn_r <= 1'b0;
				end
				REG_CTRL_B: if (!locked) ctrlB_r <= shift_r;
				REG_FN_SEL: if (!locked) fnSel_r <= {4'h0, shift_r[3:0]};
				REG_DIR_LVL: if (!locked) dirLvl_r <= shift_r;
				// only output pins take the written state
				REG_PIN_STATE: outState_r <= (pinDir & shift_r[7:4]) | (~pinDir & outState_r);
				default: begin
					if (!locked && inBank(ptr_r, REG_MIN_BASE))
						minLim_r[ptr_r[1:0]] <= shift_r;
					if (!locked && inBank(ptr_r, REG_MAX_BASE))
						maxLim_r[ptr_r[1:0]] <= shift_r;
				end
			endcase
		end
	end

	// ==========================================================
	// tach engine
	logic [1:0] tachIdx_r;
	logic [7:0] tachCnt_r;
	logic tachPhase_r;
	wire [3:0] tachDis = ctrlB_r[CB_TACH_DIS_LSB +: 4];
	wire tachActive = run && !tachDis[tachIdx_r];
	wire fallSel = tachFall[tachIdx_r];
	wire gotPeriod = tachPhase_r && fallSel;
	wire stalled = (tachCnt_r == CNT_SAT) && tachTick && !(!tachPhase_r && fallSel);
	wire storeStb = tachActive && (gotPeriod || stalled);
	wire [7:0] storeVal = gotPeriod ? tachCnt_r : CNT_SAT;
	// stall flags under speed even with the minimum at full scale
	wire underSet = (storeVal == CNT_SAT) || (storeVal > minLim_r[tachIdx_r]);
	// shorter period than maximum register means over speed
	wire overSet = storeVal < maxLim_r[tachIdx_r];
	wire [3:0] idxHot = 4'h1 << tachIdx_r;
	wire [7:0] statSet = storeStb ? {overSet ? idxHot : 4'h0, underSet ? idxHot : 4'h0} : 8'h00;
	wire statRead = rdLoad && (ptr_r == REG_FAN_STATUS);

	// fans in turn, free of the temperature pass
	always_ff @(posedge mclk) begin
		if (rst) begin
			tachIdx_r <= '0;
			tachCnt_r <= '0;
			tachPhase_r <= 1'b0;
			for (int i = 0; i < 4; i++)
				tachVal_r[i] <= CNT_SAT;
		end else if (!tachActive || storeStb) begin
			if (storeStb)
				tachVal_r[tachIdx_r] <= storeVal;
			if (run)
				tachIdx_r <= tachIdx_r + 2'h1;
			tachCnt_r <= '0;
			tachPhase_r <= 1'b0;
		end else if (!tachPhase_r && fallSel) begin
			tachPhase_r <= 1'b1;
			tachCnt_r <= '0;
		end else if (tachTick && tachCnt_r != CNT_SAT) begin
			tachCnt_r <= tachCnt_r + 8'h01;
		end
	end

	// status is sticky; a new event beats a clear-on-read in the same cycle
	always_ff @(posedge mclk) begin
		if (rst)
			fanStat_r <= '0;
		else
			fanStat_r <= (fanStat_r & ~{8{statRead}}) | statSet;
	end

	// ==========================================================
	// temperature chain
	logic [3:0] tempCh_r;
	logic [7:0] tempCnt_r;

	// pass timer restarts the chain each pass
	always_ff @(posedge mclk) begin
		if (rst || !run)
			passCnt_r <= '0;
		else if (msTick)
			passCnt_r <= (passCnt_r == passLast) ? '0 : passCnt_r + 16'h0001;
	end

	// high time of each chained pulse is stored without software
	always_ff @(posedge mclk) begin
		if (rst) begin
			tempCh_r <= '0;
			tempCnt_r <= '0;
			for (int i = 0; i < TEMP_CHANNELS; i++)
				temp_r[i] <= '0;
		end else if (!run || passStart) begin
			tempCh_r <= '0;
			tempCnt_r <= '0;
		end else begin
			if (tempRise)
				tempCnt_r <= '0;
			else if (baseTick && tempCnt_r != CNT_SAT)
				tempCnt_r <= tempCnt_r + 8'h01;
			if (tempFall && tempCh_r < 4'(TEMP_CHANNELS)) begin
				temp_r[tempCh_r] <= tempCnt_r;
				tempCh_r <= tempCh_r + 4'h1;
			end
		end
	end

	// ==========================================================
	// pin drivers, open drain pins all pulling low; fan frequency and shutdown are plain levels
	always_ff @(posedge mclk) begin
		if (rst) begin
			sdaPin <= '0;
			tempStartPin <= '0;
			alertPin <= '0;
			auxPin <= '0;
			fanFreqHigh <= '0;
			shutdownMode <= 1'b0;
		end else begin
			sdaPin <= '{out: 1'b0, oe: sdaOe_r};
			tempStartPin <= '{out: 1'b0, oe: run & ctrlA_r[CA_PIN13_START] & (passCnt_r == 16'h0000)};
			// alert pulled low on under speed or stall
			alertPin <= '{out: 1'b0, oe: |fanStat_r[3:0]};
			for (int i = 0; i < 4; i++) begin
				if (!pinEn[i])
					auxPin[i] <= '{out: 1'b0, oe: ~fanDriveIn[i]};
				else if (pinDir[i])
					auxPin[i] <= '{out: 1'b0, oe: ~(outState_r[i] ? pinPol[i] : ~pinPol[i])};
				else
					auxPin[i] <= '{out: 1'b0, oe: 1'b0};
			end
			fanFreqHigh <= {ctrlA_r[CA_HF_FAN4], ctrlB_r[CB_FREQ_LSB +: 3]};
			shutdownMode <= ctrlB_r[CB_SHUTDOWN];
		end
	end

endmodule

//--- bench/fmc_monitor_chk.sv
`timescale 1ns/1ps
module fmc_monitor_chk
	import fmc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	input fmc_od_type sdaPin,
	input wire logic [3:0] tachIn,
	input wire logic tempChainIn,
	input fmc_od_type tempStartPin,
	input wire logic [1:0] addrStrap,
	input wire logic [3:0] fanDriveIn,
	input wire logic [3:0] auxPinIn,
	input fmc_od_type [3:0] auxPin,
	input fmc_od_type alertPin,
	input wire logic [3:0] fanFreqHigh,
	input wire logic shutdownMode
);
	// ==========================================
	// helpers
	wire logic [3:0] auxOe = {auxPin[3].oe, auxPin[2].oe, auxPin[1].oe, auxPin[0].oe};
	wire logic [3:0] auxOut = {auxPin[3].out, auxPin[2].out, auxPin[1].out, auxPin[0].out};
	// no register write can land before the first acknowledge
	logic ackSeen_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			ackSeen_r <= 1'b0;
		end else if (sdaPin.oe) begin
			ackSeen_r <= 1'b1;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ==========================================
	// properties
	property p_sda_od;
		sdaPin.oe |-> !sdaPin.out;
	endproperty
	a_sda_od: assert property (p_sda_od) else $error("data pin driven high");
	property p_alert_od;
		alertPin.oe |-> !alertPin.out;
	endproperty
	a_alert_od: assert property (p_alert_od) else $error("alert driven high");
	property p_aux_od;
		(|auxOe) |-> ((auxOut & auxOe) == 4'h0);
	endproperty
	a_aux_od: assert property (p_aux_od) else $error("aux pin driven high");
	property p_rst_quiet;
		disable iff (1'b0) rst |=> !(sdaPin.oe | alertPin.oe | tempStartPin.oe | (|auxOe)) && fanFreqHigh == 4'h0 && !shutdownMode;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
	property p_fan_mode;
		!ackSeen_r && !$past(rst) |-> auxOe == ~$past(fanDriveIn);
	endproperty
	a_fan_mode: assert property (p_fan_mode) else $error("pins not in fan mode after reset");
	property p_sda_low_phase;
		$changed(sdaPin.oe) |-> !sclIn;
	endproperty
	a_sda_low_phase: assert property (p_sda_low_phase) else $error("data changed while clock high");
	property p_shut_by_bus;
		$changed(shutdownMode) |-> ##[0:4] sdaPin.oe;
	endproperty
	a_shut_by_bus: assert property (p_shut_by_bus) else $error("shutdown moved without a write");
	property p_freq_by_bus;
		$changed(fanFreqHigh) |-> ##[0:4] sdaPin.oe;
	endproperty
	a_freq_by_bus: assert property (p_freq_by_bus) else $error("frequency moved without a write");
	property p_alert_clear;
		$fell(alertPin.oe) |-> $past(sdaPin.oe, 1) || $past(sdaPin.oe, 2) || $past(sdaPin.oe, 3);
	endproperty
	a_alert_clear: assert property (p_alert_clear) else $error("alert cleared without a read");
endmodule

//--- bench/fmc_bus_master.sv
`timescale 1ns/1ps
// default quarter keeps the bus clock within its rate limit
module fmc_bus_master #(
	parameter int QUARTER = 625
)(
	input wire logic mclk,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaLow
);
	// idle bus: both lines left to their pull-ups, clock stands still
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic q();
		repeat (QUARTER) @(posedge mclk);
	endtask
	task automatic start();
		sdaLow <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sdaLow <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic stop();
		sdaLow <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sdaLow <= 1'b0;
		q();
	endtask
	// bytes msb first, data moves only while clock low
	task automatic xbyte(input logic [7:0] d, input logic ninth, output logic [7:0] got, output logic ackd);
		logic [8:0] tx;
		logic [8:0] rx;
		tx = {d, ninth};
		for (int i = 8; i >= 0; i--) begin
			sdaLow <= !tx[i];
			q();
			scl <= 1'b1;
			q();
			rx[i] = sdaLine;
			q();
			scl <= 1'b0;
			q();
		end
		got = rx[8:1];
		ackd = !rx[0];
	endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import fmc_pkg::*;
	localparam logic [7:0] PART_ID = 8'hC3; // arbitrary value
	localparam logic [7:0] MAKER_ID = 8'h3C; // arbitrary value
	localparam logic [7:0] REV_ID = 8'h07; // arbitrary value
	logic mclk, rst, tempChainIn, shutdownMode, scl, sdaLow, ok;
	logic [3:0] tachIn, fanDriveIn, auxPinIn, fanFreqHigh;
	logic [1:0] addrStrap;
	logic [6:0] devAddr;
	logic [7:0] v;
	fmc_od_type sdaPin, tempStartPin, alertPin;
	fmc_od_type [3:0] auxPin;
	int fails, testsRun;
	wire logic sdaLine = !(sdaLow | sdaPin.oe);
	wire logic [3:0] auxOe = {auxPin[3].oe, auxPin[2].oe, auxPin[1].oe, auxPin[0].oe};

	fmc_monitor #(.MS_CYCLES(250), .PART_CODE(PART_ID), .MAKER_CODE(MAKER_ID), .REV_CODE(REV_ID)) dut (
		.mclk(mclk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine), .sdaPin(sdaPin), .tachIn(tachIn),
		.tempChainIn(tempChainIn), .tempStartPin(tempStartPin), .addrStrap(addrStrap),
		.fanDriveIn(fanDriveIn), .auxPinIn(auxPinIn), .auxPin(auxPin), .alertPin(alertPin),
		.fanFreqHigh(fanFreqHigh), .shutdownMode(shutdownMode));
	// bus sped up to keep the run short; the slave only needs the filter margin
	fmc_bus_master #(.QUARTER(8)) bus (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// fan 1 tach: falling edge every 2500 cycles
	initial begin
		tachIn = 4'h0;
		forever begin
			repeat (1250) @(posedge mclk);
			tachIn[0] <= ~tachIn[0];
		end
	end

	// ==========================================
	// shared tasks
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ack);
		logic [7:0] junk;
		logic a0, a1, a2;
		bus.start();
		bus.xbyte({devAddr, 1'b0}, 1'b1, junk, a0);
		bus.xbyte(ptr, 1'b1, junk, a1);
		bus.xbyte(d, 1'b1, junk, a2);
		bus.stop();
		ack = a0 & a1 & a2;
	endtask
	task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
		logic [7:0] junk;
		logic a;
		bus.start();
		bus.xbyte({devAddr, 1'b0}, 1'b1, junk, a);
		bus.xbyte(ptr, 1'b1, junk, a);
		bus.start();
		bus.xbyte({devAddr, 1'b1}, 1'b1, junk, a);
		bus.xbyte(8'hFF, 1'b1, d, a);
		bus.stop();
	endtask
	task automatic rdchk(input string what, input logic [7:0] ptr, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
		logic [7:0] d;
		rd(ptr, d);
		cmp8(what, exp & m, d & m);
	endtask
	task automatic doReset();
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		fanDriveIn <= 4'b1010;
		repeat (3) @(posedge mclk);
		cmp8("fanmode", 8'h05, {4'h0, auxOe});
		rdchk("fnsel", REG_FN_SEL, RST_FN_SEL);
		rdchk("ctrla", REG_CTRL_A, RST_CTRL_A);
		wr(REG_PART, 8'h00, ok);
		rdchk("part", REG_PART, PART_ID);
		rdchk("maker", REG_MAKER, MAKER_ID);
		rdchk("rev", REG_REV, REV_ID);
		rdchk("unmapped", 8'h90, 8'h00);
	endtask
	task automatic t_strap();
		logic [1:0] straps [3] = '{2'b01, 2'b00, 2'b10};
		logic [6:0] addrs [3] = '{7'h2F, 7'h2C, 7'h2E};
		for (int i = 0; i < 3; i++) begin
			addrStrap <= straps[i];
			doReset();
			devAddr = addrs[i];
			wr(REG_CTRL_B, 8'h00, ok);
			cmp8("strapack", 8'h01, {7'h0, ok});
		end
		// later strap changes must not move the latched address
		addrStrap <= 2'b01;
		devAddr = 7'h2F;
		wr(REG_CTRL_B, 8'h00, ok);
		cmp8("relatch", 8'h00, {7'h0, ok});
		devAddr = 7'h2E;
		wr(REG_CTRL_B, 8'h00, ok);
		cmp8("latched", 8'h01, {7'h0, ok});
	endtask
	task automatic t_ctrl();
		wr(REG_CTRL_B, 8'h0B, ok);
		cmp8("shutdown", 8'h01, {7'h0, shutdownMode});
		cmp8("freq", 8'h05, {4'h0, fanFreqHigh});
		wr(REG_CTRL_A, 8'h90, ok);
		cmp8("freq4", 8'h0D, {4'h0, fanFreqHigh});
		wr(REG_CTRL_B, 8'hE0, ok);
		cmp8("wake", 8'h00, {7'h0, shutdownMode});
		rdchk("ctrlb", REG_CTRL_B, 8'hE0);
	endtask
	task automatic t_gpio();
		auxPinIn <= 4'b1100;
		wr(REG_FN_SEL, 8'h0F, ok);
		wr(REG_DIR_LVL, 8'hE4, ok);
		wr(REG_PIN_STATE, 8'hF0, ok);
		cmp8("drive1", 8'h02, {4'h0, auxOe});
		rdchk("state1", REG_PIN_STATE, 8'h70, 8'hF0);
		auxPinIn <= 4'b0000;
		wr(REG_PIN_STATE, 8'h00, ok);
		cmp8("drive0", 8'h01, {4'h0, auxOe});
		rdchk("state0", REG_PIN_STATE, 8'h80, 8'hF0);
		wr(REG_FN_SEL, 8'h00, ok);
		cmp8("fanback", 8'h05, {4'h0, auxOe});
	endtask
	task automatic t_monitor();
		int n;
		wr(REG_MIN_BASE, 8'h02, ok);
		wr(REG_MAX_BASE, 8'h10, ok);
		wr(REG_CTRL_A, 8'h85, ok);
		n = 0;
		while (alertPin.oe !== 1'b1 && n < 20000) begin
			@(posedge mclk);
			n++;
		end
		cmp8("alert", 8'h01, {7'h0, alertPin.oe});
		rdchk("running", REG_CTRL_A, 8'h01, 8'h01);
		// one chained pulse of about 2.4 base ticks lands in the first channel
		tempChainIn <= 1'b1;
		repeat (6000) @(posedge mclk);
		tempChainIn <= 1'b0;
		rd(REG_TEMP_BASE, v);
		cmp8("temp", 8'h01, {7'h0, v >= 8'h02 && v <= 8'h03});
		rd(REG_TACH_BASE, v);
		cmp8("tach", 8'h01, {7'h0, v >= 8'h03 && v <= 8'h05});
		rdchk("status", REG_FAN_STATUS, 8'h11, 8'h11);
		wr(REG_MIN_BASE, 8'hFF, ok);
		repeat (8000) @(posedge mclk);
		rd(REG_FAN_STATUS, v);
		repeat (8000) @(posedge mclk);
		rdchk("repeat", REG_FAN_STATUS, 8'h10, 8'h11);
		cmp8("overnoalert", 8'h00, {7'h0, alertPin.oe});
		wr(REG_CTRL_A, 8'h00, ok);
		rdchk("stopped", REG_CTRL_A, 8'h00, 8'h01);
		// lock holds until reset, so this stays last
		wr(REG_CTRL_A, 8'h08, ok);
		wr(REG_CTRL_B, 8'h01, ok);
		cmp8("lockshut", 8'h00, {7'h0, shutdownMode});
		rdchk("lockctrlb", REG_CTRL_B, 8'hE0);
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && testsRun > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#380_000;
		fails++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		tempChainIn = 1'b0;
		addrStrap = 2'b01;
		fanDriveIn = 4'h0;
		auxPinIn = 4'h0;
		fails = 0;
		testsRun = 0;
		devAddr = 7'h2F;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		t_reset();
		t_strap();
		t_ctrl();
		t_gpio();
		t_monitor();
		tally_and_finish();
	end
endmodule

bind fmc_monitor fmc_monitor_chk chk (.mclk(mclk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaPin(sdaPin),
	.tachIn(tachIn), .tempChainIn(tempChainIn), .tempStartPin(tempStartPin), .addrStrap(addrStrap),
	.fanDriveIn(fanDriveIn), .auxPinIn(auxPinIn), .auxPin(auxPin), .alertPin(alertPin),
	.fanFreqHigh(fanFreqHigh), .shutdownMode(shutdownMode));
